//--- hw/dcr_core_ctl.sv
// core clock, reset and pipeline control of the fixed-point dsp core
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps

// Summary of operation
// - four concurrent stages: fetch, decode, operand, execute
// - instruction fetched in cycle one executes fourth
// - interlocked stages stall on unresolved dependency
// - wait states stretch the machine cycle
// - power save acts only through core clock
// - stop mode keeps all state unchanged; register port writes still change the status words, cfg and hold
// - continue resumes exactly where it stopped
// - interrupt wake starts at handler address
// - registers update on rising core clock only; register port writes land on any ref_clk edge
// - reset aborts execution, keeps other state
// - reset clears listed status word bits
// - reset clears config low byte, pc
// - program address is zero during reset
// - fetch from zero one cycle after release
// - read enable rises with the first fetch
module dcr_core_ctl
	import dcr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic core_clock_input,
	input wire logic core_reset_pin,
	input wire logic stall_req,
	input wire logic irq_take,
	input wire logic [15:0] irq_vector,
	input wire logic [15:0] prog_data_in,
	input wire logic [3:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [15:0] bus_rdata,
	output logic [15:0] program_address_bus_out,
	output logic program_read_enable,
	output logic exec_valid,
	output logic [15:0] exec_addr,
	output logic [15:0] exec_word
);

	dcr_core_t q;
	dcr_core_t d;
	dcr_bus_req_t req;
	dcr_slot_t dec_in;
	dcr_slot_t dec_out;
	dcr_slot_t op_out;
	dcr_slot_t ex_in;
	dcr_slot_t ex_out;
	logic tick;
	logic running;
	logic adv;
	logic flush;

	////////////////////////////////////////////////////////////////////////
	// a cycle without core_clock_input is a wait, slow or stop cycle:
	// nothing in the core moves, so all state is kept except what register port writes change
	assign tick = core_clock_input;
	assign running = (q.state == DCR_RUN) && !core_reset_pin;
	// decode and operand move only when the machine cycle is complete and unblocked
	assign adv = tick && running && !irq_take && !stall_req
		&& !q.hold;
	assign flush = tick && (core_reset_pin || irq_take
		|| q.state == DCR_HELD);

	assign req.wr = bus_wr;
	assign req.rd = bus_rd;
	assign req.addr = bus_addr;
	assign req.wdata = bus_wdata;

	// the word on prog_data_in belongs to the address issued this cycle
	assign dec_in.valid = q.read_en;
	assign dec_in.addr = q.pc;
	assign dec_in.word = prog_data_in;

	// execute takes a bubble whenever the earlier stages are interlocked
	always_comb
	begin
		ex_in = op_out;
		if (!adv)
		begin
			ex_in.valid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		d.rdata = '0;
		if (req.wr)
		begin
			if (req.addr == DCR_OFS_CTRL)
			begin
				d.hold = req.wdata[DCR_CTRL_HOLD_BIT];
			end
			else if (req.addr == DCR_OFS_STAT_A)
			begin
				d.stat_a = req.wdata;
			end
			else if (req.addr == DCR_OFS_STAT_B)
			begin
				d.stat_b = req.wdata;
			end
			else if (req.addr == DCR_OFS_STAT_C)
			begin
				d.stat_c = req.wdata;
			end
			else if (req.addr == DCR_OFS_CFG)
			begin
				d.cfg = req.wdata;
			end
		end
		if (req.rd)
		begin
			if (req.addr == DCR_OFS_CTRL)
			begin
				d.rdata = {15'h0000, q.hold};
			end
			else if (req.addr == DCR_OFS_STAT_A)
			begin
				d.rdata = q.stat_a;
			end
			else if (req.addr == DCR_OFS_STAT_B)
			begin
				d.rdata = q.stat_b;
			end
			else if (req.addr == DCR_OFS_STAT_C)
			begin
				d.rdata = q.stat_c;
			end
			else if (req.addr == DCR_OFS_CFG)
			begin
				d.rdata = q.cfg;
			end
			else if (req.addr == DCR_OFS_PC)
			begin
				d.rdata = q.pc;
			end
			else if (req.addr == DCR_OFS_PIPE)
			begin
				d.rdata = {11'h000, q.state, q.read_en, dec_out.valid,
					op_out.valid, ex_out.valid};
			end
		end
		if (tick)
		begin
			if (core_reset_pin)
			begin
				// abort and clear only the bits that reset defines
				d.state = DCR_HELD;
				d.pc = DCR_RESET_ADDR;
				d.read_en = 1'b0;
				d.stat_a = d.stat_a & ~DCR_STAT_A_CLR;
				d.stat_b = d.stat_b & ~DCR_STAT_B_CLR;
				d.stat_c = d.stat_c & ~DCR_STAT_C_CLR;
				d.cfg = d.cfg & ~DCR_CFG_CLR;
			end
			else
			begin
				case (q.state)
					DCR_HELD:
					begin
						// first core edge after release issues address zero
						d.state = DCR_RUN;
						d.pc = DCR_RESET_ADDR;
						d.read_en = !q.hold;
					end
					DCR_RUN:
					begin
						d.read_en = !q.hold;
						if (irq_take)
						begin
							d.pc = irq_vector;
							d.read_en = 1'b1;
						end
						else if (adv)
						begin
							d.pc = q.pc + 16'h0001;
						end
					end
					default:
					begin
						d.state = DCR_HELD;
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			q.state <= DCR_HELD;
			q.pc <= DCR_RESET_ADDR;
			q.read_en <= 1'b0;
			q.hold <= 1'b0;
			q.stat_a <= DCR_POR_WORD;
			q.stat_b <= DCR_POR_WORD;
			q.stat_c <= DCR_POR_WORD;
			q.cfg <= DCR_POR_WORD;
			q.rdata <= DCR_POR_WORD;
		end
		else
		begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decode, operand fetch and execute; fetch is the pc/read_en pair
	dcr_pipe_stage u_decode (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.advance(adv),
		.flush(flush),
		.in_slot(dec_in),
		.out_slot(dec_out)
	);

	dcr_pipe_stage u_operand (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.advance(adv),
		.flush(flush),
		.in_slot(dec_out),
		.out_slot(op_out)
	);

	dcr_pipe_stage u_execute (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.advance(tick && running),
		.flush(flush),
		.in_slot(ex_in),
		.out_slot(ex_out)
	);

	assign bus_rdata = q.rdata;
	assign program_address_bus_out = q.pc;
	assign program_read_enable = q.read_en;
	assign exec_valid = ex_out.valid;
	assign exec_addr = ex_out.addr;
	assign exec_word = ex_out.word;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_clean_adv;
		adv && !core_reset_pin && !irq_take;
	endsequence

	chk_fetch_to_exec: assert property (
		(adv && !core_reset_pin && !irq_take && q.read_en)
		##1 s_clean_adv [*2]
		|=> exec_valid && exec_addr == $past(q.pc, 3))
		else $error("fetched word did not execute in the fourth cycle");

	chk_stall_bubble: assert property (
		(tick && running && stall_req && !irq_take)
		|=> !exec_valid && $stable(program_address_bus_out))
		else $error("stalled cycle advanced the pipeline");

	chk_stop_frozen: assert property (
		(!tick && !bus_wr)
		|=> $stable(q.pc) && $stable(q.stat_a) && $stable(q.cfg)
		&& $stable(exec_valid) && $stable(program_read_enable))
		else $error("state changed without a core clock");

	chk_continue_resume: assert property (
		(!tick ##1 (adv && !bus_wr))
		|=> program_address_bus_out
		== $past(program_address_bus_out) + 16'h0001)
		else $error("flow did not resume at the stop point");

	chk_irq_handler: assert property (
		(tick && running && irq_take)
		|=> program_address_bus_out == $past(irq_vector)
		&& program_read_enable && !exec_valid)
		else $error("interrupt wake did not go to the handler");

	chk_reset_clears: assert property (
		(tick && core_reset_pin && !bus_wr)
		|=> (q.stat_a & DCR_STAT_A_CLR) == 16'h0000
		&& (q.stat_b & DCR_STAT_B_CLR) == 16'h0000
		&& (q.stat_c & DCR_STAT_C_CLR) == 16'h0000
		&& (q.cfg & DCR_CFG_CLR) == 16'h0000
		&& (q.stat_a & ~DCR_STAT_A_CLR)
		== ($past(q.stat_a) & ~DCR_STAT_A_CLR)
		&& !exec_valid)
		else $error("core reset cleared wrong bits");

	chk_reset_addr_zero: assert property (
		(tick && core_reset_pin)
		|=> program_address_bus_out == DCR_RESET_ADDR
		&& !program_read_enable)
		else $error("program address not zero during reset");

	chk_first_fetch: assert property (
		(tick && q.state == DCR_HELD && !core_reset_pin && !q.hold)
		|=> program_read_enable
		&& program_address_bus_out == DCR_RESET_ADDR
		##1 (!tick || core_reset_pin || exec_valid == 1'b0))
		else $error("first fetch after reset not from zero");

	cov_reset_release: cover property (
		core_reset_pin ##1 !core_reset_pin && tick ##1 program_read_enable);
	cov_stop_resume: cover property (!tick [*4] ##1 adv);
	cov_stall_run: cover property (stall_req && running ##1 adv);
	cov_irq_wake: cover property (!tick ##1 tick && running && irq_take);

endmodule

//--- inc/dcr_pkg.sv
// shared constants and types of the core clock/reset control block
package dcr_pkg;

	localparam int DCR_DW = 16;
	localparam int DCR_AW = 16;
	localparam int DCR_RAW = 4;

	// register indices on the plain register port
	localparam logic [3:0] DCR_OFS_CTRL = 4'h0;
	localparam logic [3:0] DCR_OFS_STAT_A = 4'h1;
	localparam logic [3:0] DCR_OFS_STAT_B = 4'h2;
	localparam logic [3:0] DCR_OFS_STAT_C = 4'h3;
	localparam logic [3:0] DCR_OFS_CFG = 4'h4;
	localparam logic [3:0] DCR_OFS_PC = 4'h5;
	localparam logic [3:0] DCR_OFS_PIPE = 4'h6;

	// control register field
	localparam int DCR_CTRL_HOLD_BIT = 0;

	// bits cleared by a core reset; all others keep their value
	localparam logic [15:0] DCR_STAT_A_CLR = 16'h0801;
	localparam logic [15:0] DCR_STAT_B_CLR = 16'h0c00;
	localparam logic [15:0] DCR_STAT_C_CLR = 16'h0201;
	localparam logic [15:0] DCR_CFG_CLR = 16'h00ff;

	// start address after a core reset
	localparam logic [15:0] DCR_RESET_ADDR = 16'h0000;
	// power-on value of every register
	localparam logic [15:0] DCR_POR_WORD = 16'h0000;
	// least length of a core reset, in core clock cycles
	localparam int DCR_RESET_MIN_CYCLES = 6;

	typedef enum logic {
		DCR_HELD = 1'b0,
		DCR_RUN = 1'b1
	} dcr_state_t;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] word;
	} dcr_slot_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} dcr_bus_req_t;

	typedef struct packed {
		dcr_state_t state;
		logic [15:0] pc;
		logic read_en;
		logic hold;
		logic [15:0] stat_a;
		logic [15:0] stat_b;
		logic [15:0] stat_c;
		logic [15:0] cfg;
		logic [15:0] rdata;
	} dcr_core_t;

endpackage

//--- hw/dcr_pipe_stage.sv
// one interlocking pipeline stage register
`timescale 1ns/100ps
module dcr_pipe_stage
	import dcr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic advance,
	input wire logic flush,
	input dcr_slot_t in_slot,
	output dcr_slot_t out_slot
);

	typedef struct packed {
		dcr_slot_t slot;
	} dcr_stage_t;

	dcr_stage_t q;
	dcr_stage_t d;

	always_comb
	begin
		d = q;
		if (flush)
		begin
			d.slot.valid = 1'b0;
		end
		else if (advance)
		begin
			d.slot = in_slot;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign out_slot = q.slot;

	////////////////////////////////////////////////////////////////////////
	// a stage neither advanced nor flushed keeps its instruction
	chk_stage_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
		(!advance && !flush) |=> $stable(out_slot))
		else $error("pipeline stage changed while held");

endmodule

//--- tb/dcr_glue_model.sv
// off-core glue model: core clock enable, core reset and program memory
`timescale 1ns/100ps
module dcr_glue_model
	import dcr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [3:0] div,
	input wire logic stop,
	input wire logic wait_req,
	input wire logic rst_req,
	input wire logic [15:0] program_address_bus_out,
	input wire logic program_read_enable,
	output logic core_clock_input,
	output logic core_reset_pin,
	output logic [15:0] prog_data_in
);
	logic [3:0] cnt_q;
	logic [15:0] last_q;

	always_ff @(posedge ref_clk)
	begin
		// registered here, so reset reaches the core already synchronised
		core_reset_pin <= rst_req | !rstn;
		last_q <= prog_data_in;
		if (!rstn || stop || wait_req)
		begin
			cnt_q <= 4'h0;
			core_clock_input <= 1'b0;
		end
		else if (cnt_q >= div - 4'h1)
		begin
			cnt_q <= 4'h0;
			core_clock_input <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 4'h1;
			core_clock_input <= 1'b0;
		end
	end

	// released data lines flip so a stale word is never mistaken for a fetch
	always_comb
	begin
		prog_data_in = ~last_q;
		if (program_read_enable)
			prog_data_in = program_address_bus_out ^ 16'h5a3c;
	end
endmodule

//--- tb/tb_dcr_core_ctl.sv
// self-checking bench of the core clock, reset and pipeline control
`timescale 1ns/100ps
module tb_dcr_core_ctl
	import dcr_pkg::*;
;
	typedef struct packed {
		logic [3:0] a;
		logic [15:0] w;
		logic [15:0] e;
	} dcr_row_t;
	localparam dcr_row_t ROWS [8] = '{
		'{DCR_OFS_CTRL, 16'h0000, 16'h0000},
		'{DCR_OFS_STAT_A, 16'hffff, ~DCR_STAT_A_CLR},
		'{DCR_OFS_STAT_B, 16'hffff, ~DCR_STAT_B_CLR},
		'{DCR_OFS_STAT_C, 16'hffff, ~DCR_STAT_C_CLR},
		'{DCR_OFS_CFG, 16'hffff, ~DCR_CFG_CLR},
		'{DCR_OFS_PC, 16'hffff, DCR_RESET_ADDR},
		'{DCR_OFS_PIPE, 16'hffff, 16'h0000},
		'{4'hf, 16'hffff, 16'h0000}};
	logic ref_clk, rstn, stall_req, irq_take, bus_wr, bus_rd;
	logic stop, wait_req, rst_req, core_clock_input, core_reset_pin;
	logic program_read_enable, exec_valid;
	logic [3:0] bus_addr, div;
	logic [15:0] irq_vector, prog_data_in, bus_wdata, bus_rdata;
	logic [15:0] program_address_bus_out, exec_addr, exec_word, sa, se;
	int n_mismatch, n_tests, cyc, i;

	dcr_glue_model dcr_glue_model_i (.ref_clk(ref_clk), .rstn(rstn),
		.div(div), .stop(stop), .wait_req(wait_req), .rst_req(rst_req),
		.program_address_bus_out(program_address_bus_out),
		.program_read_enable(program_read_enable),
		.core_clock_input(core_clock_input),
		.core_reset_pin(core_reset_pin), .prog_data_in(prog_data_in));
	dcr_core_ctl dcr_core_ctl_i (.ref_clk(ref_clk), .rstn(rstn),
		.core_clock_input(core_clock_input),
		.core_reset_pin(core_reset_pin), .stall_req(stall_req),
		.irq_take(irq_take), .irq_vector(irq_vector),
		.prog_data_in(prog_data_in), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata),
		.program_address_bus_out(program_address_bus_out),
		.program_read_enable(program_read_enable),
		.exec_valid(exec_valid), .exec_addr(exec_addr),
		.exec_word(exec_word));

	always #50 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task settle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		@(negedge ref_clk);
		chk(bus_rdata, e);
	endtask

	// only valid at full clock rate: three core edges from fetch to execute
	task chk_exec(input logic [15:0] a);
		settle(3);
		chk({15'h0000, exec_valid}, 16'h0001);
		chk(exec_addr, a);
		chk(exec_word, a ^ 16'h5a3c);
		chk(program_address_bus_out, a + 16'h0003);
	endtask

	task freeze;
		settle(2);
		sa = program_address_bus_out;
		se = exec_addr;
		settle(5);
		chk(program_address_bus_out, sa);
		chk(exec_addr, se);
	endtask

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			final_report;
		end
	end

	////////////////////////////////////////////////////////////////
	initial
	begin
		{ref_clk, rstn, stall_req, irq_take, bus_wr, bus_rd} = 6'h00;
		{stop, wait_req, rst_req, bus_addr, div} = {3'h1, 4'h0, 4'h1};
		{irq_vector, bus_wdata} = 32'h0000_0000;
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		settle(1);
		chk(program_address_bus_out, 16'h0000);
		chk({15'h0000, program_read_enable}, 16'h0000);
		for (i = 0; i < 8; i++)
			wr(ROWS[i].a, ROWS[i].w);
		for (i = 0; i < 8; i++)
			rd(ROWS[i].a, ROWS[i].e);
		@(posedge ref_clk);
		rst_req <= 1'b0;
		settle(1);
		for (i = 0; i < 10 && program_read_enable !== 1'b1; i++)
			settle(1);
		chk(program_address_bus_out, DCR_RESET_ADDR);
		chk_exec(16'h0000);
		@(posedge ref_clk);
		stall_req <= 1'b1;
		settle(2);
		sa = program_address_bus_out;
		settle(4);
		chk(program_address_bus_out, sa);
		chk({15'h0000, exec_valid}, 16'h0000);
		@(posedge ref_clk);
		stall_req <= 1'b0;
		wait_req <= 1'b1;
		freeze;
		@(posedge ref_clk);
		wait_req <= 1'b0;
		stop <= 1'b1;
		freeze;
		@(posedge ref_clk);
		stop <= 1'b0;
		for (i = 0; i < 10 && program_address_bus_out === sa; i++)
			settle(1);
		chk(program_address_bus_out, sa + 16'h0001);
		@(posedge ref_clk);
		div <= 4'h3;
		settle(3);
		sa = program_address_bus_out;
		settle(9);
		chk(program_address_bus_out, sa + 16'h0003);
		@(posedge ref_clk);
		div <= 4'h1;
		settle(2);
		wr(DCR_OFS_CTRL, 16'h0001);
		settle(2);
		sa = program_address_bus_out;
		settle(3);
		chk(program_address_bus_out, sa);
		chk({15'h0000, program_read_enable}, 16'h0000);
		// run, fetch off, decode and operand held, execute empty
		rd(DCR_OFS_PIPE, 16'h0016);
		wr(DCR_OFS_CTRL, 16'h0000);
		@(posedge ref_clk);
		stop <= 1'b1;
		settle(4);
		@(posedge ref_clk);
		stop <= 1'b0;
		irq_take <= 1'b1;
		irq_vector <= 16'h0040;
		// the glue lets the clock go one cycle after stop drops
		repeat (2) @(posedge ref_clk);
		irq_take <= 1'b0;
		settle(1);
		chk(program_address_bus_out, 16'h0040);
		chk({15'h0000, exec_valid}, 16'h0000);
		chk_exec(16'h0040);
		@(posedge ref_clk);
		rst_req <= 1'b1;
		settle(8);
		chk(program_address_bus_out, 16'h0000);
		chk({14'h0000, program_read_enable, exec_valid}, 16'h0000);
		rd(DCR_OFS_STAT_A, ~DCR_STAT_A_CLR);
		rd(DCR_OFS_PC, DCR_RESET_ADDR);
		final_report;
	end
endmodule
